/* File: pcam_consts.svh */
// Constants of the configuration access unit: I/O offsets, field positions,
// reset values and PCI command codes.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef PCAM_CONSTS_SVH
`define PCAM_CONSTS_SVH

// Host I/O byte addresses of the two control ports
`define PCAM_ADDR_PORT_OFS 16'h0CF8
`define PCAM_DATA_WIN_OFS 16'h0CFC
// Reset values
`define PCAM_ADDR_PORT_RST 32'h00000000
`define PCAM_DATA_WIN_RST 32'h00000000
// Writable bits of the address port: enable, bus, agent, function, register
`define PCAM_ADDR_PORT_MASK 32'h80FFFFFC
// Field positions in the address port
`define PCAM_ENABLE_BIT 31
`define PCAM_BUS_HI 23
`define PCAM_BUS_LO 16
`define PCAM_AGENT_HI 15
`define PCAM_AGENT_LO 11
`define PCAM_FUNC_HI 10
`define PCAM_FUNC_LO 8
`define PCAM_REG_HI 7
`define PCAM_REG_LO 2
// Own identity on bus zero and the highest agent with a select line
`define PCAM_SELF_AGENT 5'h00
`define PCAM_SELF_FUNC 3'h0
`define PCAM_MAX_AGENT 5'h14
// Lowest address line used as a select line
`define PCAM_SELECT_LSB 11
// Address-phase low bits marking a Type 1 cycle
`define PCAM_TYPE1_CODE 2'h1
// PCI bus commands
`define PCAM_CMD_IO_RD 4'h2
`define PCAM_CMD_IO_WR 4'h3
`define PCAM_CMD_CFG_RD 4'hA
`define PCAM_CMD_CFG_WR 4'hB
// Read data returned after a master abort
`define PCAM_ABORT_DATA 32'hFFFFFFFF
// All four byte lanes enabled
`define PCAM_DWORD_BE 4'hF

`endif

/* File: pcam_pkg.sv */
// Types shared by the configuration access unit.
// Assumes nothing of its surroundings.
package pcam_pkg;
   // Sequencer states of the host request path
   typedef enum logic [1:0] {
      PCAM_IDLE,
      PCAM_INT,
      PCAM_PCI
   } pcam_state_e;
   // PCI bus command code
   typedef logic [3:0] pcam_cmd_t;
endpackage

/* File: pcam_cfg_if.sv */
// Interface between the host sequencer and the internal register store.
// Assumes one requester and one store on the same clock.
`timescale 1ns/100ps
interface pcam_cfg_if;
   logic req;          // One-cycle access request
   logic wr;           // Write when high
   logic [5:0] idx;    // Dword index in the store
   logic [3:0] be;     // Byte lanes of a write
   logic [31:0] wdata; // Write data
   logic [31:0] rdata; // Read data, valid with ack
   logic ack;          // One-cycle completion
   modport master(output req, wr, idx, be, wdata, input rdata, ack);
   modport slave(input req, wr, idx, be, wdata, output rdata, ack);
endinterface

/* File: pcam_addr_gen.sv */
// Address-phase generator: builds Type 0 or Type 1 configuration addresses
// from the address port contents.
// Assumes a stable address port while its output is sampled.
`timescale 1ns/100ps
`include "pcam_consts.svh"
module pcam_addr_gen import pcam_pkg::*; (
   input wire logic [31:0] i_addr_port,
   output logic [31:0] o_pci_addr,
   output logic o_type1
);
   logic [7:0] bus;   // Target bus field
   logic [4:0] agent; // Target agent field
   logic [2:0] func;  // Target function field
   logic [20:0] sel;  // Select lines 31:11

   assign bus = i_addr_port[`PCAM_BUS_HI:`PCAM_BUS_LO];
   assign agent = i_addr_port[`PCAM_AGENT_HI:`PCAM_AGENT_LO];
   assign func = i_addr_port[`PCAM_FUNC_HI:`PCAM_FUNC_LO];
   assign o_type1 = (bus != 8'h00);

   // One-hot select decode; agent zero and agents above the top get none
   always_comb begin
      sel = 21'h00000;
      // Own agent never raises line 11, even for other functions
      if (agent != `PCAM_SELF_AGENT && agent <= `PCAM_MAX_AGENT) begin
         sel[agent] = 1'b1;
      end
   end

   // Address phase layout per cycle type
   always_comb begin
      if (o_type1) begin
         // Bus, agent, function, register pass through; top byte zero
         o_pci_addr = {8'h00, i_addr_port[23:2], `PCAM_TYPE1_CODE};
      end else begin
         // Function and register pass through under the select lines
         o_pci_addr = {sel, i_addr_port[10:2], 2'h0};
      end
   end
endmodule

/* File: pcam_int_cfg.sv */
// Internal configuration store of the bridge itself, reached only through
// the host sequencer's interface.
// Assumes one request at a time; answers one cycle after each request.
`timescale 1ns/100ps
`include "pcam_consts.svh"
module pcam_int_cfg import pcam_pkg::*; #(
   parameter int DEPTH = 64,
   parameter logic [31:0] IDENT = 32'h5A5A0001 // Arbitrary identity value
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   pcam_cfg_if.slave cfg
);
   logic [31:0] mem_q [DEPTH]; // Register contents; dword 0 is read-only identity

   // Byte-lane writes; the identity dword ignores writes
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= 32'h00000000;
         end
      end else if (cfg.req && cfg.wr && cfg.idx != 6'h00) begin
         for (int b = 0; b < 4; b++) begin
            if (cfg.be[b]) begin
               mem_q[cfg.idx][b*8 +: 8] <= cfg.wdata[b*8 +: 8];
            end
         end
      end
   end

   // Read data and completion, one cycle after the request
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg.ack <= 1'b0;
         cfg.rdata <= 32'h00000000;
      end else begin
         cfg.ack <= cfg.req;
         if (cfg.req) begin
            cfg.rdata <= (cfg.idx == 6'h00) ? IDENT : mem_q[cfg.idx];
         end
      end
   end
endmodule

/* File: pcam_top.sv */
// Function
// - Address port updates only on dword access.
// - Byte or word port access goes to PCI.
// - Enable bit gates all configuration cycles.
// - Data window access becomes configuration cycle.
// - Port fields: bus, agent, function, register.
// - Bus zero: agent and function pick self or PCI.
// - Bus zero, not self: Type 0 cycle.
// - Type 0 passes port bits 10:2 through.
// - Type 0 one-hot agent select on 31:11.
// - Self is agent zero, function zero, served internally.
// - Agents above twenty: Type 0, no select.
// - Self with nonzero function: no select.
// - Nonzero bus: Type 1, bits 23:2 through.
// - Type 1: low bits 01, upper zero.
// - Only the port and window mechanism exists.
// - Internal registers reachable from host only.
//
// Top of the host-side configuration access unit: takes host I/O cycles,
// keeps the address port, serves its own registers and issues PCI cycles.
// Assumes host and PCI master logic run on i_core_clk; one request at a time.
`timescale 1ns/100ps
`include "pcam_consts.svh"
module pcam_top import pcam_pkg::*; #(
   parameter int REG_DEPTH = 64
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_io_req,
   input wire logic i_io_wr,
   input wire logic [15:2] i_io_addr,
   input wire logic [3:0] i_io_be,
   input wire logic [31:0] i_io_wdata,
   output logic o_io_busy,
   output logic o_io_done,
   output logic [31:0] o_io_rdata,
   output logic o_io_mabort,
   output logic o_pci_req,
   output logic [3:0] o_pci_cmd,
   output logic [31:0] o_pci_addr,
   output logic [3:0] o_pci_be,
   output logic [31:0] o_pci_wdata,
   input wire logic i_pci_done,
   input wire logic [31:0] i_pci_rdata,
   input wire logic i_pci_mabort,
   output logic [31:0] o_addr_port
);
   pcam_state_e state_q; // Sequencer state
   pcam_state_e state_d; // Next sequencer state
   logic take;           // Host request accepted this cycle
   logic hit_port;       // Host addresses the address port
   logic hit_win;        // Host addresses the data window
   logic dword;          // All four byte lanes enabled
   logic port_dword;     // Dword access to the address port
   logic cfg_en;         // Configuration cycles enabled
   logic cfg_path;       // Request becomes a configuration cycle
   logic self_hit;       // Bus 0, agent 0, function 0
   logic [31:0] gen_addr; // Configuration address phase
   logic gen_type1;      // Generated address is Type 1
   pcam_cmd_t cmd_d;     // Command for a PCI-bound request

   pcam_cfg_if cfg();

   // Address phase from the current port contents
   pcam_addr_gen u_addr_gen (
      .i_addr_port(o_addr_port),
      .o_pci_addr(gen_addr),
      .o_type1(gen_type1)
   );

   // Own register store; only this sequencer connects to it, no PCI target path
   pcam_int_cfg #(.DEPTH(REG_DEPTH)) u_int_cfg (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .cfg(cfg.slave)
   );

   // Request decode; only these two I/O locations exist, no mapped space
   assign hit_port = ({i_io_addr, 2'h0} == `PCAM_ADDR_PORT_OFS);
   assign hit_win = ({i_io_addr, 2'h0} == `PCAM_DATA_WIN_OFS);
   assign dword = (i_io_be == `PCAM_DWORD_BE);
   assign port_dword = hit_port && dword;
   // Requests while busy are dropped silently; the host must wait for done
   assign take = i_io_req && (state_q == PCAM_IDLE);
   assign cfg_en = o_addr_port[`PCAM_ENABLE_BIT];
   assign cfg_path = hit_win && cfg_en;
   // Bus zero and agent zero with function zero means self
   assign self_hit = (o_addr_port[`PCAM_BUS_HI:`PCAM_BUS_LO] == 8'h00)
      && (o_addr_port[`PCAM_AGENT_HI:`PCAM_AGENT_LO] == `PCAM_SELF_AGENT)
      && (o_addr_port[`PCAM_FUNC_HI:`PCAM_FUNC_LO] == `PCAM_SELF_FUNC);

   // Command selection: configuration cycles only when enabled
   // Reads and writes differ only in the low command bit
   always_comb begin
      if (cfg_path) begin
         cmd_d = i_io_wr ? `PCAM_CMD_CFG_WR : `PCAM_CMD_CFG_RD;
      end else begin
         cmd_d = i_io_wr ? `PCAM_CMD_IO_WR : `PCAM_CMD_IO_RD;
      end
   end

   // Next state
   // A dword port access never leaves idle, so it may repeat every cycle
   always_comb begin
      state_d = state_q;
      case (state_q)
         PCAM_IDLE: begin
            if (take && !port_dword) begin
               // Self is answered inside; everything else goes to PCI
               state_d = (cfg_path && self_hit) ? PCAM_INT : PCAM_PCI;
            end
         end
         PCAM_INT: begin
            if (cfg.ack) begin
               state_d = PCAM_IDLE;
            end
         end
         PCAM_PCI: begin
            if (i_pci_done) begin
               state_d = PCAM_IDLE;
            end
         end
         default: begin
            state_d = PCAM_IDLE;
         end
      endcase
   end

   // State register and busy flag
   // Busy follows the next state, so it falls on the edge that issues done
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= PCAM_IDLE;
         o_io_busy <= 1'b0;
      end else begin
         state_q <= state_d;
         o_io_busy <= (state_d != PCAM_IDLE);
      end
   end

   // Address port: written only by a full dword host write
   // A narrow write never lands here; it leaves as a plain I/O cycle
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_addr_port <= `PCAM_ADDR_PORT_RST;
      end else if (take && port_dword && i_io_wr) begin
         // Reserved bits 30:24 and 1:0 are held at zero
         o_addr_port <= i_io_wdata & `PCAM_ADDR_PORT_MASK;
      end
   end

   // Internal store request, one cycle wide
   // Fields are captured on every take; only req says whether they matter
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg.req <= 1'b0;
         cfg.wr <= 1'b0;
         cfg.idx <= 6'h00;
         cfg.be <= 4'h0;
         cfg.wdata <= `PCAM_DATA_WIN_RST;
      end else begin
         cfg.req <= take && !port_dword && cfg_path && self_hit;
         if (take) begin
            cfg.wr <= i_io_wr;
            cfg.idx <= o_addr_port[`PCAM_REG_HI:`PCAM_REG_LO];
            cfg.be <= i_io_be;
            cfg.wdata <= i_io_wdata;
         end
      end
   end

   // PCI master request: raised on take, held until the PCI side finishes
   // Fields stand after the cycle ends; only req tells the far side to act
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pci_req <= 1'b0;
         o_pci_cmd <= `PCAM_CMD_IO_RD;
         o_pci_addr <= 32'h00000000;
         o_pci_be <= 4'h0;
         o_pci_wdata <= 32'h00000000;
      end else if (take && !port_dword && !(cfg_path && self_hit)) begin
         o_pci_req <= 1'b1;
         o_pci_cmd <= cmd_d;
         o_pci_be <= i_io_be;
         o_pci_wdata <= i_io_wdata;
         if (cfg_path) begin
            // Type 0 on bus zero, Type 1 elsewhere
            o_pci_addr <= gen_addr;
         end else begin
            // Ordinary I/O cycle at the host address
            o_pci_addr <= {16'h0000, i_io_addr, 2'h0};
         end
      end else if (i_pci_done) begin
         o_pci_req <= 1'b0;
      end
   end

   // Host completion and read data
   // Done is a one-cycle pulse; read data holds until the next done
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_io_done <= 1'b0;
         o_io_rdata <= 32'h00000000;
         o_io_mabort <= 1'b0;
      end else begin
         o_io_done <= 1'b0;
         o_io_mabort <= 1'b0;
         if (take && port_dword) begin
            // Port access completes at once; a read returns current contents
            o_io_done <= 1'b1;
            o_io_rdata <= o_addr_port;
         end else if (state_q == PCAM_INT && cfg.ack) begin
            o_io_done <= 1'b1;
            o_io_rdata <= cfg.rdata;
         end else if (state_q == PCAM_PCI && i_pci_done) begin
            // A master abort reads as all ones, as on any PCI bus
            o_io_done <= 1'b1;
            o_io_mabort <= i_pci_mabort;
            o_io_rdata <= i_pci_mabort ? `PCAM_ABORT_DATA : i_pci_rdata;
         end
      end
   end

   // Checks beside the logic they guard
   // Antecedents sample the taking edge, save the done, request and store checks; |=> consequents look one edge later, |-> ones the same edge
   // The port write and its completion land on the same edge
   a_port_dword_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && port_dword && i_io_wr |=> o_addr_port == ($past(i_io_wdata) & 32'h80FFFFFC)
      ##0 o_io_done && !o_pci_req)
      else $error("address port not loaded by dword write");

   // Narrow port references leave the port untouched and go out as I/O
   a_port_narrow_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && hit_port && !dword |=> o_pci_req && $stable(o_addr_port)
      && (o_pci_cmd == 4'h2 || o_pci_cmd == 4'h3) && o_pci_addr == 32'h00000CF8)
      else $error("narrow port access not passed to PCI");

   // With the enable clear the window is just another I/O location
   a_disabled_window: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && hit_win && !cfg_en |=> o_pci_req && o_pci_cmd == ($past(i_io_wr) ? 4'h3 : 4'h2))
      else $error("window access while disabled not plain I/O");

   // Window access starts a configuration cycle; its request still stands one edge later unless done came
   a_window_cfg_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && hit_win && cfg_en && !self_hit |=> o_pci_req
      && o_pci_cmd == ($past(i_io_wr) ? 4'hB : 4'hA) ##1 o_pci_req || $past(i_pci_done))
      else $error("window access did not start a configuration cycle");

   // Type 1 marker in the low bits, nothing above the bus field
   a_type1_layout: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && cfg_path && o_addr_port[23:16] != 8'h00 |=> o_pci_addr[1:0] == 2'h1
      && o_pci_addr[31:24] == 8'h00 && o_pci_addr[23:2] == $past(o_addr_port[23:2]))
      else $error("bad Type 1 address phase");

   // Agent zero never raises line 11, whatever the function
   a_type0_select: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && cfg_path && !self_hit && o_addr_port[23:16] == 8'h00 |=> o_pci_addr[1:0] == 2'h0
      && !o_pci_addr[11] && $onehot0(o_pci_addr[31:11])
      && o_pci_addr[10:2] == $past(o_addr_port[10:2]))
      else $error("bad Type 0 address phase");

   // Absent agents still get a full Type 0 cycle, which ends in abort
   a_no_select_abort: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && cfg_path && o_addr_port[23:16] == 8'h00 && (o_addr_port[15:11] > 5'h14
      || (o_addr_port[15:11] == 5'h00 && o_addr_port[10:8] != 3'h0)) |=> o_pci_req
      && o_pci_addr[31:11] == 21'h000000)
      else $error("select line raised for absent agent");

   // Store answers two edges after take, so done is seen on the third
   a_self_internal: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && cfg_path && self_hit |=> !o_pci_req ##1 !o_pci_req ##1 o_io_done && !o_pci_req)
      else $error("self access leaked to PCI or was slow");

   // Completion, abort flag and idle all follow done by one edge
   a_pci_completion: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      state_q == PCAM_PCI && i_pci_done |=> o_io_done && !o_pci_req && !o_io_busy
      && o_io_mabort == $past(i_pci_mabort))
      else $error("PCI completion not returned to host");

   // A PCI request only ever stands inside a busy host access
   a_req_while_busy: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_pci_req |-> o_io_busy)
      else $error("PCI request outside a busy access");

   // No configuration command may leave while the enable is clear
   a_cfg_needs_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && !cfg_en && !port_dword |=> o_pci_req && o_pci_cmd[3:1] != 3'h5)
      else $error("configuration command issued while disabled");

   // Address and command hold for as long as the request stands
   a_pci_fields_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_pci_req && !i_pci_done |=> o_pci_req && $stable(o_pci_addr) && $stable(o_pci_cmd))
      else $error("PCI request fields moved before done");

   // The store is only ever asked while serving the bridge itself
   a_store_req_self: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cfg.req |-> state_q == PCAM_INT && !o_pci_req)
      else $error("store request outside a self access");

   // A dword port read returns the port contents at once
   a_port_read_back: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      take && port_dword && !i_io_wr |=> o_io_done && o_io_rdata == $past(o_addr_port))
      else $error("address port read back wrong");
endmodule

/* File: pcam_pci_model.sv */
// Behavioural PCI target side seen by the configuration access unit.
// Assumes one cycle at a time on the core clock, request held until done.
`timescale 1ns/100ps
module pcam_pci_model (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_pci_req,
   input wire logic [3:0] i_pci_cmd,
   input wire logic [31:0] i_pci_addr,
   input wire logic [1:0] i_delay,
   output logic o_pci_done,
   output logic [31:0] o_pci_rdata,
   output logic o_pci_mabort
);
   logic [1:0] st_q;  // 0 idle, 1 waiting, 2 ended
   logic [1:0] cnt_q; // Wait states still to insert
   logic no_sel;      // Config cycle that selects no target

   // No select line and no Type 1 marker means nobody claims the cycle
   assign no_sel = (i_pci_cmd[3:1] == 3'h5) && (i_pci_addr[1:0] == 2'h0)
      && (i_pci_addr[31:11] == 21'h0);

   // Target sequencing with a wait chosen by the bench
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= 2'h0;
         cnt_q <= 2'h0;
         o_pci_done <= 1'b0;
         o_pci_rdata <= 32'h0;
         o_pci_mabort <= 1'b0;
      end else begin
         o_pci_done <= 1'b0;
         // Data lines toggle outside done so stale values never match
         o_pci_rdata <= ~o_pci_rdata;
         o_pci_mabort <= ~o_pci_mabort;
         case (st_q)
            2'h0: if (i_pci_req) begin
               st_q <= 2'h1;
               cnt_q <= i_delay;
            end
            2'h1: if (cnt_q == 2'h0) begin
               st_q <= 2'h2;
               o_pci_done <= 1'b1;
               o_pci_mabort <= no_sel;
               o_pci_rdata <= no_sel ? 32'hFFFFFFFF : i_pci_addr ^ 32'h3C3C0000;
            end else begin
               cnt_q <= cnt_q - 2'h1;
            end
            default: if (!i_pci_req) begin
               // Wait for the request to drop before taking another
               st_q <= 2'h0;
            end
         endcase
      end
   end
endmodule

/* File: pcam_bench.sv */
// Self-checking bench of the configuration access unit.
// Assumes the store's default identity value and the PCI target model.
`timescale 1ns/100ps
`include "pcam_consts.svh"
module pcam_bench;
   localparam logic [31:0] SELF_IDENT = 32'h5A5A0001; // Arbitrary, store default
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic io_req = 1'b0;
   logic io_wr = 1'b0;
   logic [15:2] io_addr = 14'h0;
   logic [3:0] io_be = 4'h0;
   logic [31:0] io_wdata = 32'h0;
   logic [1:0] delay = 2'h0;
   logic io_busy, io_done, io_mabort, pci_req, pci_done, pci_mabort;
   logic [31:0] io_rdata, pci_addr, pci_wdata, pci_rdata, addr_port;
   logic [3:0] pci_cmd, pci_be;
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 32'h88EB;
   logic [33:0] exp_q[$]; // {check data, abort, read data}
   logic [71:0] pci_q[$]; // {cmd, be, addr, wdata}
   logic [33:0] e_io;
   logic [71:0] e_pci;
   logic req_d = 1'b0;

   pcam_top i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_io_req(io_req), .i_io_wr(io_wr),
      .i_io_addr(io_addr), .i_io_be(io_be), .i_io_wdata(io_wdata), .o_io_busy(io_busy),
      .o_io_done(io_done), .o_io_rdata(io_rdata), .o_io_mabort(io_mabort),
      .o_pci_req(pci_req), .o_pci_cmd(pci_cmd), .o_pci_addr(pci_addr), .o_pci_be(pci_be),
      .o_pci_wdata(pci_wdata), .i_pci_done(pci_done), .i_pci_rdata(pci_rdata),
      .i_pci_mabort(pci_mabort), .o_addr_port(addr_port));
   pcam_pci_model i_pci (.i_core_clk(clk), .i_rst_n(rst_n), .i_pci_req(pci_req),
      .i_pci_cmd(pci_cmd), .i_pci_addr(pci_addr), .i_delay(delay), .o_pci_done(pci_done),
      .o_pci_rdata(pci_rdata), .o_pci_mabort(pci_mabort));

   // Free-running core clock
   initial begin
      forever #5 clk = ~clk;
   end

   // Verdict and end of run
   task finish_test;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // One comparison, counted
   task check(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", name, e, g);
         error_cnt++;
      end
   endtask

   // Note an expected PCI cycle
   task pexp(input logic [3:0] cmd, input logic [3:0] be, input logic [31:0] a,
         input logic [31:0] d);
      pci_q.push_back({cmd, be, a, d});
   endtask

   // One host I/O access, entered at a falling edge, ends when done is seen
   task io(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d,
         input logic chk, input logic ab, input logic [31:0] rd);
      int k;
      exp_q.push_back({chk, ab, rd});
      delay = 2'($random(seed));
      io_req = 1'b1;
      io_wr = wr;
      io_addr = a[15:2];
      io_be = be;
      io_wdata = d;
      @(negedge clk);
      io_req = 1'b0;
      for (k = 0; k < 40 && io_done !== 1'b1; k++) @(negedge clk);
      if (k == 40) check("io_done", 32'h1, 32'h0);
      // One idle edge, so the next call never re-raises req in this time step
      @(negedge clk);
   endtask

   // Watch completions and PCI requests, compare with the oldest note
   always @(negedge clk) begin
      if (io_done === 1'b1) begin
         e_io = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
         check("io_mabort", {31'h0, e_io[32]}, {31'h0, io_mabort});
         check("io_busy_done", 32'h0, {31'h0, io_busy});
         if (e_io[33]) check("io_rdata", e_io[31:0], io_rdata);
      end
      if (pci_req === 1'b1 && req_d !== 1'b1) begin
         e_pci = (pci_q.size() > 0) ? pci_q.pop_front() : 72'h0;
         check("pci_cmd", {28'h0, e_pci[71:68]}, {28'h0, pci_cmd});
         check("io_busy", 32'h1, {31'h0, io_busy});
         check("pci_be", {28'h0, e_pci[67:64]}, {28'h0, pci_be});
         check("pci_addr", e_pci[63:32], pci_addr);
         check("pci_wdata", e_pci[31:0], pci_wdata);
      end
      req_d = pci_req;
   end

   // Watchdog, far beyond the roughly five hundred cycles the sequence needs
   initial begin
      #300000;
      error_cnt++;
      finish_test();
   end

   // Main sequence
   initial begin
      logic [31:0] port, d, a;
      logic [7:0] bus;
      logic wr;
      int i;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check("addr_port_rst", `PCAM_ADDR_PORT_RST, addr_port);
      check("pci_cmd_rst", 32'h2, {28'h0, pci_cmd});
      io(1'b0, `PCAM_ADDR_PORT_OFS, 4'hF, 32'h0, 1'b1, 1'b0, 32'h0);
      // Back-to-back port writes, reserved bits read back as zero
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         port = d & `PCAM_ADDR_PORT_MASK;
         io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, d, 1'b0, 1'b0, 32'h0);
         check("addr_port", port, addr_port);
      end
      io(1'b0, `PCAM_ADDR_PORT_OFS, 4'hF, 32'h0, 1'b1, 1'b0, port);
      // Word references on both halves pass through to PCI
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         wr = i[0];
         a = {16'h0, `PCAM_ADDR_PORT_OFS};
         pexp(wr ? `PCAM_CMD_IO_WR : `PCAM_CMD_IO_RD, 4'h3 << (i * 2 % 4), a, d);
         io(wr, `PCAM_ADDR_PORT_OFS, 4'h3 << (i * 2 % 4), d, !wr, 1'b0, a ^ 32'h3C3C0000);
         check("addr_port_kept", port, addr_port);
      end
      // Enable clear: window and the other mechanism's space are plain I/O
      io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, 32'h00010800, 1'b0, 1'b0, 32'h0);
      pexp(`PCAM_CMD_IO_RD, 4'hF, 32'h00000CFC, 32'h0);
      io(1'b0, `PCAM_DATA_WIN_OFS, 4'hF, 32'h0, 1'b1, 1'b0, 32'h3C3C0CFC);
      pexp(`PCAM_CMD_IO_WR, 4'hF, 32'h0000C010, d);
      io(1'b1, 16'hC010, 4'hF, d, 1'b0, 1'b0, 32'h0);
      // Type 0 sweep over every agent number above the bridge
      for (i = 1; i < 32; i++) begin
         d = $random(seed);
         wr = d[31];
         port = {1'b1, 15'h0, i[4:0], d[10:2], 2'h0};
         io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, port, 1'b0, 1'b0, 32'h0);
         a = {21'h0, port[10:2], 2'h0};
         if (i <= 20) a[11 + i] = 1'b1;
         pexp(wr ? `PCAM_CMD_CFG_WR : `PCAM_CMD_CFG_RD, d[27:24] | 4'h1, a, d);
         io(wr, `PCAM_DATA_WIN_OFS, d[27:24] | 4'h1, d, !wr, i > 20,
            (i > 20) ? 32'hFFFFFFFF : a ^ 32'h3C3C0000);
      end
      // Own registers answer inside, no PCI cycle noted
      io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, 32'h80000000, 1'b0, 1'b0, 32'h0);
      io(1'b0, `PCAM_DATA_WIN_OFS, 4'hF, 32'h0, 1'b1, 1'b0, SELF_IDENT);
      io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, 32'h80000014, 1'b0, 1'b0, 32'h0);
      d = $random(seed);
      io(1'b1, `PCAM_DATA_WIN_OFS, 4'hF, d, 1'b0, 1'b0, 32'h0);
      io(1'b0, `PCAM_DATA_WIN_OFS, 4'hF, 32'h0, 1'b1, 1'b0, d);
      // Other functions of the bridge go out with no select line
      for (i = 1; i < 8; i++) begin
         port = 32'h80000010 | (i << 8);
         io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, port, 1'b0, 1'b0, 32'h0);
         pexp(`PCAM_CMD_CFG_RD, 4'hF, {21'h0, port[10:2], 2'h0}, 32'h0);
         io(1'b0, `PCAM_DATA_WIN_OFS, 4'hF, 32'h0, 1'b1, 1'b1, 32'hFFFFFFFF);
      end
      // Type 1 cycles to random non-zero buses
      for (i = 0; i < 6; i++) begin
         d = $random(seed);
         wr = i[0];
         bus = (d[23:16] == 8'h0) ? 8'h01 : d[23:16];
         port = {1'b1, 7'h0, bus, d[15:2], 2'h0};
         io(1'b1, `PCAM_ADDR_PORT_OFS, 4'hF, port, 1'b0, 1'b0, 32'h0);
         a = {8'h0, port[23:2], `PCAM_TYPE1_CODE};
         pexp(wr ? `PCAM_CMD_CFG_WR : `PCAM_CMD_CFG_RD, 4'hF, a, d);
         io(wr, `PCAM_DATA_WIN_OFS, 4'hF, d, !wr, 1'b0, a ^ 32'h3C3C0000);
      end
      @(negedge clk);
      check("notes_left", 32'h0, 32'(exp_q.size() + pci_q.size()));
      finish_test();
   end
endmodule
